// file: include/gpio_pkg.sv
// Register map, field widths and reset values of the eight-pin I/O port
package gpio_pkg;
  localparam int unsigned PIN_COUNT       = 8;
  localparam int unsigned ADDR_WIDTH      = 10;

  typedef logic [PIN_COUNT-1:0]  pins_t;
  typedef logic [ADDR_WIDTH-1:0] word_addr_t;

  // Word indices (byte offset divided by four)
  localparam word_addr_t DATA_LAST_IDX    = 10'h0ff;
  localparam word_addr_t DIR_IDX          = 10'h100;
  localparam word_addr_t SENSE_IDX        = 10'h101;
  localparam word_addr_t DUAL_IDX         = 10'h102;
  localparam word_addr_t POLARITY_IDX     = 10'h103;
  localparam word_addr_t UNMASK_IDX       = 10'h104;
  localparam word_addr_t RAW_STATUS_IDX   = 10'h105;
  localparam word_addr_t GATED_STATUS_IDX = 10'h106;
  localparam word_addr_t CLEAR_IDX        = 10'h107;
  localparam word_addr_t OWNER_IDX        = 10'h108;
  localparam word_addr_t DRIVE_LOW_IDX    = 10'h140;
  localparam word_addr_t DRIVE_MID_IDX    = 10'h141;
  localparam word_addr_t DRIVE_HIGH_IDX   = 10'h142;
  localparam word_addr_t OPEN_DRAIN_IDX   = 10'h143;
  localparam word_addr_t PULL_UP_IDX      = 10'h144;
  localparam word_addr_t PULL_DOWN_IDX    = 10'h145;
  localparam word_addr_t SLEW_IDX         = 10'h146;
  localparam word_addr_t DIGITAL_EN_IDX   = 10'h147;
  localparam word_addr_t IDENT_FIRST_IDX  = 10'h3f4;

  // Reset values
  localparam pins_t DRIVE_LOW_RST         = 8'hff;
  localparam pins_t PULL_UP_RST           = 8'hff;
  localparam pins_t DIGITAL_EN_RST        = 8'hff;
  localparam pins_t OWNER_RST_DEFAULT     = 8'h00;
  localparam pins_t ZERO_PINS             = 8'h00;

  // Identification words, values arbitrary
  localparam logic [7:0] IDENT_ROM [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h5a, 8'h00,
                                            8'h2c, 8'h03, 8'h11, 8'h22, 8'h33, 8'h44};
endpackage : gpio_pkg

// file: core/pin_edge_detect.sv
// Pin synchroniser and per-pin trigger detection
`timescale 1ns/100ps
module pin_edge_detect #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pin_async,
  input  wire logic [WIDTH-1:0] sense,
  input  wire logic [WIDTH-1:0] dual,
  input  wire logic [WIDTH-1:0] polarity,
  output logic      [WIDTH-1:0] pin_sync,
  output logic      [WIDTH-1:0] edge_hit,
  output logic      [WIDTH-1:0] level_hit
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= pin_async;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign pin_sync = sync_q;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_pin
      logic rise;
      logic fall;
      assign rise = sync_q[g] & ~prev_q[g];
      assign fall = ~sync_q[g] & prev_q[g];
      assign edge_hit[g]  = ~sense[g] & (dual[g] ? (rise | fall) : (polarity[g] ? rise : fall));
      assign level_hit[g] = sense[g] & (sync_q[g] == polarity[g]);
    end
  endgenerate
endmodule : pin_edge_detect

// file: core/gpio_port.sv
// Eight-pin I/O port with masked data access and pin triggers
// Behaviour
// - Address bits 9:2 mask data access
// - Write changes only mask-selected bits
// - Read returns zero for unselected bits
// - Data register aliases over 256 words
// - One combined interrupt output
// - Edge trigger pending until software clears
// - Sense and dual-edge select detection
// - Polarity selects low/falling or high/rising
// - Unmask bit gates pin interrupt
// - Raw and gated status views
// - Write one clears pending trigger
// - Port B pin four fires converter trigger
// - Ownership hands pin to peripheral
// - Pad settings writable and presented
// - Reset: inputs, debug pins peripheral-owned
// - Read-only identification words
// - Direction selects input or output
// - Read gives output value or pin
//
// The register offsets and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/100ps
module gpio_port
  import gpio_pkg::*;
#(
  parameter gpio_pkg::pins_t OWNER_RST   = gpio_pkg::OWNER_RST_DEFAULT,
  parameter bit              CONV_SOURCE = 1'b0,
  parameter int unsigned     CONV_PIN    = 4
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic [11:0]          avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  input  wire logic [7:0]           pin_in,
  output logic      [7:0]           pin_out,
  output logic      [7:0]           pin_oe_n,
  input  wire logic [7:0]           periph_out,
  input  wire logic [7:0]           periph_drive,
  output logic      [7:0]           periph_in,
  output logic      [7:0]           pad_drive_low,
  output logic      [7:0]           pad_drive_mid,
  output logic      [7:0]           pad_drive_high,
  output logic      [7:0]           pad_open_drain,
  output logic      [7:0]           pad_pull_up,
  output logic      [7:0]           pad_pull_down,
  output logic      [7:0]           pad_slew_limit,
  output logic      [7:0]           pad_digital_en,
  output logic                      port_irq,
  output logic                      converter_trigger
);
  import gpio_pkg::*;

  pins_t      data_q;
  pins_t      direction_select_q;
  pins_t      trigger_sense_select_q;
  pins_t      dual_edge_select_q;
  pins_t      trigger_polarity_select_q;
  pins_t      interrupt_unmask_q;
  pins_t      edge_pending_q;
  pins_t      peripheral_ownership_select_q;
  pins_t      drive_low_select_q;
  pins_t      drive_mid_select_q;
  pins_t      drive_high_select_q;
  pins_t      open_drain_select_q;
  pins_t      pull_up_select_q;
  pins_t      pull_down_select_q;
  pins_t      slew_limit_select_q;
  pins_t      digital_input_enable_q;
  pins_t      pin_sync;
  pins_t      edge_hit;
  pins_t      level_hit;
  pins_t      raw_trigger_status;
  pins_t      gated_trigger_status;
  pins_t      byte_data;
  pins_t      data_view;
  word_addr_t idx;
  logic       ack_q;
  logic       wr_go;
  logic       byte_wr;
  logic       conv_q;
  logic       conv_seen_q;

  // Index of the word addressed; one wait cycle per access
  assign idx     = avs_address[11:2];
  // Write lands on the accepting edge, never while stalled
  assign wr_go   = avs_write & ack_q;
  assign byte_wr = wr_go & avs_byteenable[0];
  assign byte_data = avs_writedata[7:0];
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  function automatic logic is_data(input word_addr_t a);
    return a <= DATA_LAST_IDX;
  endfunction : is_data

  function automatic logic hit(input word_addr_t a, input word_addr_t b, input logic go);
    return go && (a == b);
  endfunction : hit

  pin_edge_detect #(
    .WIDTH (PIN_COUNT)
  ) pin_edge_detect_i (
    .clk       (clk),
    .rst       (rst),
    .pin_async (pin_in),
    .sense     (trigger_sense_select_q),
    .dual      (dual_edge_select_q),
    .polarity  (trigger_polarity_select_q),
    .pin_sync  (pin_sync),
    .edge_hit  (edge_hit),
    .level_hit (level_hit)
  );

  // input pins capture the pin, output pins keep written value
  assign data_view = (data_q & direction_select_q) | (pin_sync & ~direction_select_q & digital_input_enable_q);

  // masked data write at any alias
  always_ff @(posedge clk) begin
    if (rst) begin
      data_q <= ZERO_PINS;
    end else if (byte_wr && is_data(idx)) begin
      data_q <= (data_q & ~idx[7:0]) | (byte_data & idx[7:0]);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      direction_select_q <= ZERO_PINS;
    end else if (hit(idx, DIR_IDX, byte_wr)) begin
      direction_select_q <= byte_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      trigger_sense_select_q <= ZERO_PINS;
    end else if (hit(idx, SENSE_IDX, byte_wr)) begin
      trigger_sense_select_q <= byte_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dual_edge_select_q <= ZERO_PINS;
    end else if (hit(idx, DUAL_IDX, byte_wr)) begin
      dual_edge_select_q <= byte_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      trigger_polarity_select_q <= ZERO_PINS;
    end else if (hit(idx, POLARITY_IDX, byte_wr)) begin
      trigger_polarity_select_q <= byte_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      interrupt_unmask_q <= ZERO_PINS;
    end else if (hit(idx, UNMASK_IDX, byte_wr)) begin
      interrupt_unmask_q <= byte_data;
    end
  end

  // ownership, debug pins default to peripheral
  always_ff @(posedge clk) begin
    if (rst) begin
      peripheral_ownership_select_q <= OWNER_RST;
    end else if (hit(idx, OWNER_IDX, byte_wr)) begin
      peripheral_ownership_select_q <= byte_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      drive_low_select_q <= DRIVE_LOW_RST;
    end else if (hit(idx, DRIVE_LOW_IDX, byte_wr)) begin
      drive_low_select_q <= byte_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      drive_mid_select_q <= ZERO_PINS;
    end else if (hit(idx, DRIVE_MID_IDX, byte_wr)) begin
      drive_mid_select_q <= byte_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      drive_high_select_q <= ZERO_PINS;
    end else if (hit(idx, DRIVE_HIGH_IDX, byte_wr)) begin
      drive_high_select_q <= byte_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      open_drain_select_q <= ZERO_PINS;
    end else if (hit(idx, OPEN_DRAIN_IDX, byte_wr)) begin
      open_drain_select_q <= byte_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pull_up_select_q <= PULL_UP_RST;
    end else if (hit(idx, PULL_UP_IDX, byte_wr)) begin
      pull_up_select_q <= byte_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pull_down_select_q <= ZERO_PINS;
    end else if (hit(idx, PULL_DOWN_IDX, byte_wr)) begin
      pull_down_select_q <= byte_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      slew_limit_select_q <= ZERO_PINS;
    end else if (hit(idx, SLEW_IDX, byte_wr)) begin
      slew_limit_select_q <= byte_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      digital_input_enable_q <= DIGITAL_EN_RST;
    end else if (hit(idx, DIGITAL_EN_IDX, byte_wr)) begin
      digital_input_enable_q <= byte_data;
    end
  end

  // sticky edge triggers, a new edge beats the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      edge_pending_q <= ZERO_PINS;
    end else if (hit(idx, CLEAR_IDX, byte_wr)) begin
      edge_pending_q <= (edge_pending_q & ~byte_data) | edge_hit;
    end else begin
      edge_pending_q <= edge_pending_q | edge_hit;
    end
  end

  // level triggers follow the pin while held
  assign raw_trigger_status   = (edge_pending_q & ~trigger_sense_select_q) | level_hit;
  assign gated_trigger_status = raw_trigger_status & interrupt_unmask_q;
  assign port_irq = |gated_trigger_status;

  // one-cycle converter pulse when gated pin four rises
  // Rising of gated status keeps a held level from firing every cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      conv_q      <= 1'b0;
      conv_seen_q <= 1'b0;
    end else begin
      conv_seen_q <= gated_trigger_status[CONV_PIN];
      conv_q      <= CONV_SOURCE & gated_trigger_status[CONV_PIN] & ~conv_seen_q;
    end
  end
  assign converter_trigger = conv_q;

  // pin drive; open drain drives only low
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (peripheral_ownership_select_q[i]) begin
        pin_out[i]  = periph_out[i];
        pin_oe_n[i] = ~(periph_drive[i] & (~open_drain_select_q[i] | ~periph_out[i]));
      end else begin
        pin_out[i]  = data_q[i];
        pin_oe_n[i] = ~(direction_select_q[i] & (~open_drain_select_q[i] | ~data_q[i]));
      end
    end
  end

  assign periph_in      = pin_sync & digital_input_enable_q;
  assign pad_drive_low  = drive_low_select_q;
  assign pad_drive_mid  = drive_mid_select_q;
  assign pad_drive_high = drive_high_select_q;
  assign pad_open_drain = open_drain_select_q;
  assign pad_pull_up    = pull_up_select_q;
  assign pad_pull_down  = pull_down_select_q;
  assign pad_slew_limit = slew_limit_select_q;
  assign pad_digital_en = digital_input_enable_q;

  // Read data registered; unmapped words read zero
  always_ff @(posedge clk) begin
    if (rst) begin
      avs_readdata <= '0;
    end else if (avs_read && !ack_q) begin
      avs_readdata <= '0;
      if (is_data(idx)) begin
        avs_readdata[7:0] <= data_view & idx[7:0];
      end else begin
        case (idx)
          DIR_IDX:          avs_readdata[7:0] <= direction_select_q;
          SENSE_IDX:        avs_readdata[7:0] <= trigger_sense_select_q;
          DUAL_IDX:         avs_readdata[7:0] <= dual_edge_select_q;
          POLARITY_IDX:     avs_readdata[7:0] <= trigger_polarity_select_q;
          UNMASK_IDX:       avs_readdata[7:0] <= interrupt_unmask_q;
          RAW_STATUS_IDX:   avs_readdata[7:0] <= raw_trigger_status;
          GATED_STATUS_IDX: avs_readdata[7:0] <= gated_trigger_status;
          OWNER_IDX:        avs_readdata[7:0] <= peripheral_ownership_select_q;
          DRIVE_LOW_IDX:    avs_readdata[7:0] <= drive_low_select_q;
          DRIVE_MID_IDX:    avs_readdata[7:0] <= drive_mid_select_q;
          DRIVE_HIGH_IDX:   avs_readdata[7:0] <= drive_high_select_q;
          OPEN_DRAIN_IDX:   avs_readdata[7:0] <= open_drain_select_q;
          PULL_UP_IDX:      avs_readdata[7:0] <= pull_up_select_q;
          PULL_DOWN_IDX:    avs_readdata[7:0] <= pull_down_select_q;
          SLEW_IDX:         avs_readdata[7:0] <= slew_limit_select_q;
          DIGITAL_EN_IDX:   avs_readdata[7:0] <= digital_input_enable_q;
          default: begin
            if (idx >= IDENT_FIRST_IDX) begin
              avs_readdata[7:0] <= IDENT_ROM[4'(idx - IDENT_FIRST_IDX)];
            end
          end
        endcase
      end
    end
  end
endmodule : gpio_port

// file: tb/gpio_port_properties.sv
// Checker on the I/O port's ports, bound into every port instance
`timescale 1ns/100ps
module gpio_port_check
  import gpio_pkg::*;
#(
  parameter gpio_pkg::pins_t OWNER_RST = gpio_pkg::OWNER_RST_DEFAULT
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [11:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [7:0]  pin_in,
  input wire logic [7:0]  pin_oe_n,
  input wire logic [7:0]  periph_drive,
  input wire logic [7:0]  periph_in,
  input wire logic [7:0]  pad_drive_low,
  input wire logic [7:0]  pad_pull_up,
  input wire logic [7:0]  pad_pull_down,
  input wire logic [7:0]  pad_digital_en,
  input wire logic        port_irq,
  input wire logic        converter_trigger
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  mask_read_a: assert property (
    avs_read && avs_waitrequest && avs_address[11:10] == 2'b00 |=>
    (avs_readdata[7:0] & ~$past(avs_address[9:2])) == 8'h00) else $error("unselected data bit read high");
  upper_zero_a: assert property (avs_readdata[31:8] == 24'h0) else $error("upper read bits set");
  irq_status_a: assert property (
    avs_read && avs_waitrequest && avs_address[11:2] == GATED_STATUS_IDX |=>
    (|avs_readdata[7:0]) == $past(port_irq)) else $error("irq differs from gated status");
  irq_dead_a: assert property (
    avs_write && avs_waitrequest && avs_address[11:2] == UNMASK_IDX && avs_byteenable[0]
    && avs_writedata[7:0] == 8'h00 |-> ##2 !port_irq) else $error("irq with all pins masked");
  // Pulse only follows a raised irq
  trig_irq_a: assert property (converter_trigger |-> $past(port_irq)) else $error("trigger without irq");
  pad_write_a: assert property (
    avs_write && avs_waitrequest && avs_address[11:2] == PULL_DOWN_IDX && avs_byteenable[0] |->
    ##2 pad_pull_down == $past(avs_writedata[7:0], 2)) else $error("pad setting not written");
  reset_pads_a: assert property (disable iff (1'b0) $fell(rst) |-> pad_drive_low == 8'hff &&
    pad_pull_up == 8'hff && pad_digital_en == 8'hff && pad_pull_down == 8'h00 && !port_irq &&
    pin_oe_n == ~(OWNER_RST & periph_drive)) else $error("reset defaults wrong");
  sync_a: assert property (!$past(rst) && !$past(rst, 2) |->
    periph_in == ($past(pin_in, 2) & pad_digital_en)) else $error("pin not two-flop synchronised");
endmodule : gpio_port_check

bind gpio_port gpio_port_check #(.OWNER_RST(OWNER_RST)) gpio_port_check_i (.clk, .rst, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .pin_in,
  .pin_oe_n, .periph_drive, .periph_in, .pad_drive_low, .pad_pull_up, .pad_pull_down, .pad_digital_en,
  .port_irq, .converter_trigger);

// file: tb/pin_partner.sv
// External pin model: drivers, pad pulls and resolved pin levels
`timescale 1ns/100ps
module pin_partner (
  input  wire logic       clk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  input  wire logic [7:0] pull_up,
  input  wire logic [7:0] pull_down,
  input  wire logic [7:0] ext_level,
  input  wire logic [7:0] ext_drive,
  output logic      [7:0] pin_in
);
  logic [7:0] float_q = 8'h5a;
  // Undriven pins wander, so a stale level never passes
  always @(posedge clk) float_q <= ~float_q;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
      else if (ext_drive[i]) pin_in[i] = ext_level[i];
      else if (pull_up[i] || pull_down[i]) pin_in[i] = pull_up[i];
      else pin_in[i] = float_q[i];
    end
  end
endmodule : pin_partner

// file: tb/gpio_port_bench.sv
// Self-checking bench for the eight-pin I/O port
`timescale 1ns/100ps
module gpio_port_bench;
  import gpio_pkg::*;
  localparam pins_t PAD_RST [8] = '{DRIVE_LOW_RST, 8'h00, 8'h00, 8'h00, PULL_UP_RST, 8'h00, 8'h00, DIGITAL_EN_RST};
  // Trigger rows: rising, falling, both x2, level high, level low
  localparam bit [5:0] SNS = 6'b110000, DUL = 6'b001100, POL = 6'b010001, ST = 6'b101010;
  logic        clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [11:0] avs_address = 12'h000;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic        avs_waitrequest, port_irq, converter_trigger;
  logic [7:0]  periph_out = 8'h80, periph_drive = 8'h80, ext_level = 8'hff, ext_drive = 8'hff;
  logic [7:0]  pin_in, pin_out, pin_oe_n, pull_up, pull_down, rd;
  int          err_total = 0, total_checks = 0, cycles = 0, trig_n = 0;

  gpio_port #(.OWNER_RST(8'h80), .CONV_SOURCE(1'b1), .CONV_PIN(4)) gpio_port_i (
    .clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf),
    .avs_readdata, .avs_waitrequest, .pin_in, .pin_out, .pin_oe_n, .periph_out, .periph_drive,
    .periph_in(), .pad_drive_low(), .pad_drive_mid(), .pad_drive_high(), .pad_open_drain(),
    .pad_pull_up(pull_up), .pad_pull_down(pull_down), .pad_slew_limit(), .pad_digital_en(),
    .port_irq, .converter_trigger);
  pin_partner pin_partner_i (.clk, .pin_out, .pin_oe_n, .pull_up, .pull_down, .ext_level, .ext_drive, .pin_in);

  initial forever #4 clk = ~clk;
  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (converter_trigger === 1'b1) trig_n++;
    if (cycles == 20000) begin
      err_total++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Request held until waitrequest is sampled low
  task automatic bus(input logic wr, input word_addr_t w, input logic [7:0] d);
    @(posedge clk);
    avs_address <= {w, 2'b00};
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic rd_chk(input string what, input word_addr_t w, input logic [7:0] exp);
    bus(1'b0, w, 8'h00);
    check(what, rd, exp);
  endtask : rd_chk

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    check("owned pin drive", pin_oe_n, 8'h7f);
    for (int i = 0; i < 7; i++) rd_chk("control reset", DIR_IDX + i, 8'h00);
    rd_chk("owner reset", OWNER_IDX, 8'h80);
    for (int i = 0; i < 8; i++) rd_chk("pad reset", DRIVE_LOW_IDX + i, PAD_RST[i]);
    for (int i = 0; i < 12; i++) rd_chk("ident", IDENT_FIRST_IDX + i, IDENT_ROM[i]);
    bus(1'b1, IDENT_FIRST_IDX + 4, 8'h00);
    rd_chk("ident read-only", IDENT_FIRST_IDX + 4, IDENT_ROM[4]);
    rd_chk("unmapped", 10'h200, 8'h00);
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, DRIVE_LOW_IDX + i, 8'h3c);
      rd_chk("pad write", DRIVE_LOW_IDX + i, 8'h3c);
      bus(1'b1, DRIVE_LOW_IDX + i, PAD_RST[i]);
    end
    $display("reset and pad test done");
    bus(1'b1, OWNER_IDX, 8'h00);
    bus(1'b1, DIR_IDX, 8'hff);
    bus(1'b1, 10'h026, 8'heb);
    rd_chk("masked write", DATA_LAST_IDX, 8'h22);
    check("pin drive", pin_out, 8'h22);
    check("pin enable", pin_oe_n, 8'h00);
    bus(1'b1, 10'h031, 8'hff);
    rd_chk("masked read", 10'h031, 8'h31);
    rd_chk("alias", DATA_LAST_IDX, 8'h33);
    rd_chk("empty mask", 10'h000, 8'h00);
    bus(1'b1, DIR_IDX, 8'h00);
    ext_level <= 8'ha5;
    repeat (3) @(posedge clk);
    rd_chk("input read", DATA_LAST_IDX, 8'ha5);
    bus(1'b1, DIGITAL_EN_IDX, 8'h0f);
    rd_chk("digital off", DATA_LAST_IDX, 8'h05);
    bus(1'b1, DIGITAL_EN_IDX, 8'hff);
    // Released pins settle at the pad pull-up
    ext_drive <= 8'h00;
    repeat (3) @(posedge clk);
    rd_chk("pulled up", DATA_LAST_IDX, 8'hff);
    ext_drive <= 8'hff;
    $display("data test done");
    for (int m = 0; m < 6; m++) begin
      bus(1'b1, UNMASK_IDX, 8'h00);
      bus(1'b1, SENSE_IDX, {3'h0, SNS[m], 4'h0});
      bus(1'b1, DUAL_IDX, {3'h0, DUL[m], 4'h0});
      bus(1'b1, POLARITY_IDX, {3'h0, POL[m], 4'h0});
      ext_level <= {3'h0, ST[m], 4'h0};
      repeat (5) @(posedge clk);
      bus(1'b1, CLEAR_IDX, 8'hff);
      bus(1'b1, UNMASK_IDX, 8'h10);
      trig_n = 0;
      ext_level <= {3'h0, !ST[m], 4'h0};
      repeat (5) @(posedge clk);
      rd_chk("raw", RAW_STATUS_IDX, 8'h10);
      rd_chk("gated", GATED_STATUS_IDX, 8'h10);
      check("irq", {7'h0, port_irq}, 8'h01);
      check("trigger", trig_n[7:0], 8'h01);
      bus(1'b1, UNMASK_IDX, 8'h00);
      rd_chk("gated off", GATED_STATUS_IDX, 8'h00);
      check("irq off", {7'h0, port_irq}, 8'h00);
      bus(1'b1, CLEAR_IDX, 8'h00);
      rd_chk("raw kept", RAW_STATUS_IDX, 8'h10);
      bus(1'b1, CLEAR_IDX, 8'h10);
      rd_chk("raw cleared", RAW_STATUS_IDX, {3'h0, SNS[m], 4'h0});
      $display("trigger mode %0d done", m);
    end
    wrap_up();
  end
endmodule : gpio_port_bench
